// ### src/irqsr_top.sv
// Notes on behaviour
// - reading misc status clears the bits it returned
// - timer elapse sets misc bit 1
// - processing to idle transition sets misc bit 2
// - tone detection done sets misc bit 3
// - status bit 0 shows busy engine
// - status bit 1 shows phase, resets one
// - status bit 2 shows tone interrupt
// - overrun bit sticks until clear write
// - status bit 4 shows sync pin level
// - status bit 5 shows external interrupt
// - status bit 6 ors enabled misc flags
// - status bit 7 ors all fifo flags
// - block n bit 2k tx, 2k+1 rx
// - hdlc fifo flags each end of frame
// - transparent fifo flags at programmed rate
// - block seven holds fifos 28 to 31
// - overview bit 7 set while block7 pending
// - block read clears flags; overview read doesnt
// - events during clearing read are kept
// - misc flags recorded masked or not
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module irqsr_top
  import irqsr_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  srst_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [ADDR_W-1:0]     paddr_i,
  input  wire logic [DATA_W-1:0]     pwdata_i,
  output logic      [DATA_W-1:0]     prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire irqsr_misc_ev_s        misc_ev_i,
  input  wire irqsr_fifo_ev_s        tx_ev_i [NFIFO],
  input  wire irqsr_fifo_ev_s        rx_ev_i [NFIFO]
);

  // ==========================================================
  // apb decode
  // ==========================================================
  logic [7:0]  idx;
  logic        aligned;
  logic        setup;
  logic        done;
  logic        cap_r;
  logic        err_r;
  logic [7:0]  rdat_r;
  logic [7:0]  rdat_nxt;
  logic        rd_ok;
  logic        wr_ok;

  logic [7:0]  misc_r;
  logic [7:0]  misc_mask_r;
  logic [7:0]  fen_r [NBLK];
  logic [7:0]  blk_r [NBLK];
  logic [7:0]  overview;
  logic [7:0]  chip_stat;
  logic        phase_r;
  logic        busy_r;
  logic        sync_r;
  logic        ext_r;
  logic        ovr_r;

  assign idx     = paddr_i[9:2];
  assign aligned = (paddr_i[1:0] == 2'b00);
  // setup missed while frozen is taken on the next enabled edge
  assign setup   = clk_en_i & psel_i & ~cap_r;
  // capture flag lets a frozen setup edge delay the answer
  assign done    = clk_en_i & psel_i & penable_i & cap_r;

  assign pready_o  = psel_i & penable_i & clk_en_i & cap_r;
  assign pslverr_o = pready_o & err_r;
  assign prdata_o  = {24'h000000, rdat_r};

  always_comb begin
    rd_ok    = 1'b0;
    rdat_nxt = 8'h00;
    if (aligned) begin
      if (idx == IDX_OVERVIEW) begin
        rd_ok    = 1'b1;
        rdat_nxt = overview;
      end else if (idx == IDX_MISC_STAT) begin
        rd_ok    = 1'b1;
        rdat_nxt = misc_r;
      end else if (idx == IDX_CHIP_STAT) begin
        rd_ok    = 1'b1;
        rdat_nxt = chip_stat;
      end else if (idx >= IDX_BLK0 && idx <= IDX_BLK7) begin
        rd_ok    = 1'b1;
        rdat_nxt = blk_r[idx[2:0]];
      end
    end
  end

  assign wr_ok = aligned & ((idx == IDX_MISC_MASK) |
                 (idx == IDX_STEP_RESET) |
                 (idx >= IDX_FEN0 && idx <= IDX_FEN7));

  // read value is frozen at setup; later clear uses the same copy
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cap_r  <= 1'b0;
      err_r  <= 1'b0;
      rdat_r <= 8'h00;
    end else if (setup) begin
      cap_r  <= 1'b1;
      err_r  <= pwrite_i ? ~wr_ok : ~rd_ok;
      rdat_r <= pwrite_i ? 8'h00 : rdat_nxt;
    end else if (done) begin
      cap_r  <= 1'b0;
    end
  end

  logic rd_misc;
  logic wr_mask;
  logic wr_step;
  assign rd_misc = done & ~pwrite_i & ~err_r & idx == IDX_MISC_STAT;
  assign wr_mask = done & pwrite_i & ~err_r & idx == IDX_MISC_MASK;
  assign wr_step = done & pwrite_i & ~err_r & idx == IDX_STEP_RESET;

  // ==========================================================
  // write registers
  // ==========================================================
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      misc_mask_r <= MASK_RST;
    end else if (wr_mask) begin
      misc_mask_r <= pwdata_i[7:0] & MISC_VALID;
    end
  end

  // ==========================================================
  // miscellaneous interrupt flags
  // ==========================================================
  logic [7:0] misc_set;
  logic       phase_end;

  assign phase_end = clk_en_i & phase_r & ~misc_ev_i.frame_work_phase;

  always_comb begin
    misc_set = 8'h00;
    misc_set[MISC_TIMER_BIT] = misc_ev_i.timer_elapsed;
    misc_set[MISC_PHASE_BIT] = phase_end;
    misc_set[MISC_TONE_BIT] = misc_ev_i.tone_done;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      misc_r <= FLAG_RST;
    end else if (clk_en_i) begin
      misc_r <= ((misc_r & ~(rd_misc ? rdat_r : 8'h00)) | misc_set)
                & MISC_VALID;
    end
  end

  // ==========================================================
  // chip status sources
  // ==========================================================
  // phase resets to one
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      phase_r <= PHASE_RST;
      busy_r  <= 1'b0;
      sync_r  <= 1'b0;
      ext_r   <= 1'b0;
    end else if (clk_en_i) begin
      phase_r <= misc_ev_i.frame_work_phase;
      busy_r  <= misc_ev_i.busy;
      sync_r  <= misc_ev_i.sync_level;
      ext_r   <= misc_ev_i.ext_irq;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ovr_r <= 1'b0;
    end else if (clk_en_i) begin
      if (misc_ev_i.overrun) begin
        ovr_r <= 1'b1;
      end else if (wr_step && pwdata_i[OVR_CLR_BIT]) begin
        ovr_r <= 1'b0;
      end
    end
  end

  always_comb begin
    chip_stat = 8'h00;
    chip_stat[ST_BUSY]  = busy_r;
    chip_stat[ST_PHASE] = phase_r;
    chip_stat[ST_TONE]  = misc_r[MISC_TONE_BIT];
    chip_stat[ST_OVR]   = ovr_r;
    chip_stat[ST_SYNC]  = sync_r;
    chip_stat[ST_EXT]   = ext_r;
    chip_stat[ST_MISC]  = |(misc_r & misc_mask_r);
    chip_stat[ST_FIFO]  = |overview;
  end

  // ==========================================================
  // fifo interrupt blocks
  // ==========================================================
  genvar gb;
  generate
    for (gb = 0; gb < NBLK; gb++) begin : g_blk
      logic [7:0] set;
      logic       rd_blk;
      logic       wr_fen;
      genvar      gk;

      assign rd_blk = done & ~pwrite_i & ~err_r &
                      idx == IDX_BLK0 + 8'(gb);
      assign wr_fen = done & pwrite_i & ~err_r &
                      idx == IDX_FEN0 + 8'(gb);

      for (gk = 0; gk < 8; gk++) begin : g_bit
        irqsr_fifo_ev_s ev;
        logic [9:0]     cnt_r;
        logic [9:0]     lim;
        logic           tick;

        // even bits tx, odd bits rx
        assign ev  = (gk % 2 == 1) ? rx_ev_i[gb*4 + gk/2]
                           : tx_ev_i[gb*4 + gk/2];
        assign lim  = (TRP_BASE << ev.transparent_irq_rate) - 10'h001;
        assign tick = ev.byte_done & (cnt_r == lim);

        // transparent byte count, one per fifo direction
        always_ff @(posedge clock_i) begin
          if (srst_i) begin
            cnt_r <= 10'h000;
          end else if (clk_en_i) begin
            // hdlc mode parks the count so a mode switch starts clean
            if (ev.hdlc_mode) begin
              cnt_r <= 10'h000;
            end else if (ev.byte_done) begin
              cnt_r <= tick ? 10'h000 : cnt_r + 10'h001;
            end
          end
        end

        assign set[gk] = fen_r[gb][gk] &
                         (ev.hdlc_mode ? ev.eof : tick);
      end

      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          fen_r[gb] <= MASK_RST;
        end else if (wr_fen) begin
          fen_r[gb] <= pwdata_i[7:0];
        end
      end

      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          blk_r[gb] <= FLAG_RST;
        end else if (clk_en_i) begin
          blk_r[gb] <= (blk_r[gb] & ~(rd_blk ? rdat_r : 8'h00)) | set;
        end
      end

      assign overview[gb] = |blk_r[gb];
    end
  endgenerate

  // ==========================================================
  // checks
  // ==========================================================
  a_misc_read_clear: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (rd_misc && misc_set == 8'h00 && misc_r == rdat_r)
      |=> misc_r == 8'h00)
    else $error("misc status not cleared by read");

  a_timer_flag_set: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (clk_en_i && misc_ev_i.timer_elapsed) |=> misc_r[MISC_TIMER_BIT])
    else $error("timer flag not set");

  a_phase_end_flag: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (clk_en_i && phase_r && !misc_ev_i.frame_work_phase)
      |=> misc_r[MISC_PHASE_BIT] && !phase_r)
    else $error("phase end flag not set");

  a_tone_flag_set: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (clk_en_i && misc_ev_i.tone_done)
      |=> misc_r[MISC_TONE_BIT] && chip_stat[ST_TONE])
    else $error("tone flag not set");

  a_busy_follows: assert property (
    @(posedge clock_i) disable iff (srst_i)
    clk_en_i |=> chip_stat[ST_BUSY] == $past(misc_ev_i.busy))
    else $error("busy bit does not follow engine");

  a_overrun_sticky: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (ovr_r && !wr_step) |=> ovr_r)
    else $error("overrun bit lost without clear");

  a_reserved_zero: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (misc_r & ~MISC_VALID) == 8'h00)
    else $error("reserved misc bit set");

  a_read_keeps_new: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (rd_misc && misc_ev_i.timer_elapsed)
      |=> misc_r[MISC_TIMER_BIT] ##1 misc_r[MISC_TIMER_BIT])
    else $error("event during read lost");

  a_block7_view: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (clk_en_i && |g_blk[7].set) |=> overview[7] && chip_stat[ST_FIFO])
    else $error("block 7 overview not set");

  a_block_read_clear: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (g_blk[7].rd_blk && g_blk[7].set == 8'h00 && blk_r[7] == rdat_r)
      |=> blk_r[7] == 8'h00)
    else $error("block flags not cleared by read");

  a_overview_keeps: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (done && !pwrite_i && !err_r && idx == IDX_OVERVIEW)
      |=> (overview & $past(overview)) == $past(overview))
    else $error("overview read cleared a bit");

  a_sync_follows: assert property (
    @(posedge clock_i) disable iff (srst_i)
    clk_en_i |=> chip_stat[ST_SYNC] == $past(misc_ev_i.sync_level))
    else $error("sync bit does not follow pin");

  a_ext_follows: assert property (
    @(posedge clock_i) disable iff (srst_i)
    clk_en_i |=> chip_stat[ST_EXT] == $past(misc_ev_i.ext_irq))
    else $error("external bit does not follow input");

  a_rate_tick_flag: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (clk_en_i && g_blk[0].g_bit[7].tick && fen_r[0][7]
     && !g_blk[0].g_bit[7].ev.hdlc_mode) |=> blk_r[0][7])
    else $error("transparent rate flag not set");

endmodule

`default_nettype wire

// ### src/irqsr_pkg.sv
package irqsr_pkg;

  // ==========================================================
  // bus and register map (word indices, byte address = 4*idx)
  // ==========================================================
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NFIFO  = 32;
  localparam int unsigned NBLK   = 8;

  localparam logic [7:0] IDX_STEP_RESET = 8'h0e;
  localparam logic [7:0] IDX_OVERVIEW   = 8'h10;
  localparam logic [7:0] IDX_MISC_STAT  = 8'h11;
  localparam logic [7:0] IDX_MISC_MASK  = 8'h11;
  localparam logic [7:0] IDX_CHIP_STAT  = 8'h1c;
  localparam logic [7:0] IDX_BLK0       = 8'hc8;
  localparam logic [7:0] IDX_BLK7       = 8'hcf;
  localparam logic [7:0] IDX_FEN0       = 8'hd8;
  localparam logic [7:0] IDX_FEN7       = 8'hdf;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int unsigned MISC_TIMER_BIT = 1;
  localparam int unsigned MISC_PHASE_BIT = 2;
  localparam int unsigned MISC_TONE_BIT  = 3;
  localparam logic [7:0]  MISC_VALID     = 8'h0e;
  localparam int unsigned OVR_CLR_BIT    = 2;

  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_PHASE = 1;
  localparam int unsigned ST_TONE  = 2;
  localparam int unsigned ST_OVR   = 3;
  localparam int unsigned ST_SYNC  = 4;
  localparam int unsigned ST_EXT   = 5;
  localparam int unsigned ST_MISC  = 6;
  localparam int unsigned ST_FIFO  = 7;

  // ==========================================================
  // reset values and timing
  // ==========================================================
  localparam logic [7:0] FLAG_RST  = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic       PHASE_RST = 1'b1;
  localparam logic [9:0] TRP_BASE  = 10'h040;

  typedef struct packed {
    logic timer_elapsed;
    logic frame_work_phase;
    logic tone_done;
    logic busy;
    logic overrun;
    logic sync_level;
    logic ext_irq;
  } irqsr_misc_ev_s;

  typedef struct packed {
    logic       hdlc_mode;
    logic [1:0] transparent_irq_rate;
    logic       eof;
    logic       byte_done;
  } irqsr_fifo_ev_s;

endpackage

// ### dv/irqsr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// apb host model
module irqsr_host
  import irqsr_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              pready_i,
  input  wire logic              pslverr_i,
  input  wire logic [DATA_W-1:0] prdata_i,
  output logic                   psel_o,
  output logic                   penable_o,
  output logic                   pwrite_o,
  output logic [ADDR_W-1:0]      paddr_o,
  output logic [DATA_W-1:0]      pwdata_o
);
  logic [DATA_W-1:0] rd;
  logic              err;
  int                tmo = 0;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = '0;
    pwdata_o  = '0;
  end

  // entered just after a rising edge; idle edge after release
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
    int n;
    n = 0;
    psel_o   <= 1'b1;
    pwrite_o <= w;
    paddr_o  <= {idx, 2'b00};
    pwdata_o <= {24'h0, d};
    @(posedge clock_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_i !== 1'b1 && n < 64);
    rd  = prdata_i;
    err = pslverr_i;
    if (n >= 64) tmo++;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 64; k++) begin
      xfer(1'b0, IDX_CHIP_STAT, 8'h00);
      if (rd[ST_BUSY] === 1'b0) break;
    end
    if (k == 64) tmo++;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import irqsr_pkg::*;
;
  typedef struct packed {
    logic [1:0] k;
    logic [4:0] n;
    logic [7:0] idx;
    logic [7:0] exp;
  } irqsr_row_s;

  logic              clk  = 1'b0;
  logic              srst = 1'b1;
  logic              clk_en = 1'b1;
  logic              psel;
  logic              pen;
  logic              pwr;
  logic              prdy;
  logic              perr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwd;
  logic [DATA_W-1:0] prd;
  irqsr_misc_ev_s    mev;
  irqsr_fifo_ev_s    tev [NFIFO];
  irqsr_fifo_ev_s    rev [NFIFO];
  irqsr_row_s        r;
  int                error_cnt = 0;
  int                n_checks  = 0;
  // kind 2 = misc bit n, 0 = tx eof, 1 = rx eof
  irqsr_row_s rows [9] = '{
    '{2'h2, 5'h06, 8'h11, 8'h02}, '{2'h2, 5'h04, 8'h11, 8'h08},
    '{2'h0, 5'h00, 8'hc8, 8'h01}, '{2'h1, 5'h05, 8'hc9, 8'h08},
    '{2'h0, 5'h0a, 8'hca, 8'h10}, '{2'h1, 5'h0f, 8'hcb, 8'h80},
    '{2'h0, 5'h16, 8'hcd, 8'h10}, '{2'h0, 5'h1c, 8'hcf, 8'h01},
    '{2'h1, 5'h1f, 8'hcf, 8'h80}};

  initial forever #25 clk = ~clk;

  irqsr_top u_irqsr_top (
    .clock_i(clk), .srst_i(srst), .clk_en_i(clk_en), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .misc_ev_i(mev), .tx_ev_i(tev), .rx_ev_i(rev));

  irqsr_host u_irqsr_host (
    .clock_i(clk), .pready_i(prdy), .pslverr_i(perr), .prdata_i(prd),
    .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr),
    .pwdata_o(pwd));

  // ==========
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic e = 1'b0);
    u_irqsr_host.xfer(1'b0, idx, 8'h00);
    chk(u_irqsr_host.rd[7:0], exp);
    chk({6'h0, u_irqsr_host.err, |u_irqsr_host.rd[31:8]}, {6'h0, e, 1'b0});
    if (u_irqsr_host.tmo != 0) report_and_stop();
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic e = 1'b0);
    u_irqsr_host.xfer(1'b1, idx, d);
    chk({7'h0, u_irqsr_host.err}, {7'h0, e});
    if (u_irqsr_host.tmo != 0) report_and_stop();
  endtask

  task automatic msig(input logic [2:0] b, input logic v);
    mev[b] <= v;
    @(posedge clk);
  endtask

  task automatic pulse_fifo(input logic [4:0] f, input logic rx);
    if (rx) rev[f].eof <= 1'b1;
    else tev[f].eof <= 1'b1;
    @(posedge clk);
    rev[f].eof <= 1'b0;
    tev[f].eof <= 1'b0;
    @(posedge clk);
  endtask

  task automatic report_and_stop();
    error_cnt += u_irqsr_host.tmo;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard well above the longest sequence
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  // ==========
  // main sequence
  initial begin
    mev = '0;
    mev.frame_work_phase = 1'b1;
    foreach (tev[i]) tev[i] = 5'h10;
    foreach (rev[i]) rev[i] = 5'h10;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(IDX_CHIP_STAT, 8'h02);
    rd(IDX_MISC_STAT, 8'h00);
    rd(IDX_OVERVIEW, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) wr(8'(IDX_FEN0 + i), 8'hff);
    foreach (rows[i]) begin
      r = rows[i];
      if (r.k == 2'h2) begin
        msig(r.n[2:0], 1'b1);
        msig(r.n[2:0], 1'b0);
      end else
        pulse_fifo(r.n, r.k[0]);
      rd(r.idx, r.exp);
      rd(r.idx, 8'h00);
    end
    $display("test rows done");
    msig(3'h5, 1'b0);
    rd(IDX_CHIP_STAT, 8'h00);
    rd(IDX_MISC_STAT, 8'h04);
    msig(3'h5, 1'b1);
    msig(3'h3, 1'b1);
    msig(3'h1, 1'b1);
    msig(3'h0, 1'b1);
    rd(IDX_CHIP_STAT, 8'h33);
    // host polls while the engine is still busy
    fork
      u_irqsr_host.wait_idle();
      begin
        repeat (8) @(posedge clk);
        mev.busy <= 1'b0;
      end
    join
    if (u_irqsr_host.tmo != 0) report_and_stop();
    msig(3'h1, 1'b0);
    msig(3'h0, 1'b0);
    rd(IDX_CHIP_STAT, 8'h02);
    $display("test status done");
    msig(3'h2, 1'b1);
    msig(3'h2, 1'b0);
    rd(IDX_MISC_STAT, 8'h00);
    rd(IDX_CHIP_STAT, 8'h0a);
    rd(IDX_CHIP_STAT, 8'h0a);
    wr(IDX_STEP_RESET, 8'h04);
    rd(IDX_CHIP_STAT, 8'h02);
    $display("test overrun done");
    wr(IDX_MISC_MASK, 8'h02);
    msig(3'h4, 1'b1);
    msig(3'h4, 1'b0);
    rd(IDX_CHIP_STAT, 8'h06);
    rd(IDX_MISC_STAT, 8'h08);
    rd(IDX_CHIP_STAT, 8'h02);
    msig(3'h6, 1'b1);
    msig(3'h6, 1'b0);
    rd(IDX_CHIP_STAT, 8'h42);
    // event lands on the clearing edge and must survive
    fork
      rd(IDX_MISC_STAT, 8'h02);
      begin
        @(posedge clk);
        mev.timer_elapsed <= 1'b1;
        @(posedge clk);
        mev.timer_elapsed <= 1'b0;
      end
    join
    rd(IDX_MISC_STAT, 8'h02);
    rd(IDX_CHIP_STAT, 8'h02);
    $display("test mask done");
    pulse_fifo(5'h1d, 1'b0);
    rd(IDX_OVERVIEW, 8'h80);
    rd(IDX_OVERVIEW, 8'h80);
    rd(IDX_CHIP_STAT, 8'h82);
    rd(IDX_BLK7, 8'h04);
    rd(IDX_OVERVIEW, 8'h00);
    rd(IDX_CHIP_STAT, 8'h02);
    $display("test overview done");
    for (int q = 0; q < 4; q++) begin
      rev[3] <= {1'b0, 2'(q), 2'b00};
      @(posedge clk);
      repeat ((64 << q) - 1) begin
        rev[3].byte_done <= 1'b1;
        @(posedge clk);
        rev[3].byte_done <= 1'b0;
        @(posedge clk);
      end
      rd(IDX_BLK0, 8'h00);
      rev[3].byte_done <= 1'b1;
      @(posedge clk);
      rev[3] <= 5'h10;
      @(posedge clk);
      rd(IDX_BLK0, 8'h80);
    end
    $display("test transparent done");
    // events while frozen are dropped; a frozen setup waits
    clk_en <= 1'b0;
    msig(3'h6, 1'b1);
    msig(3'h6, 1'b0);
    fork
      rd(IDX_MISC_STAT, 8'h00);
      begin
        repeat (4) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    rd(IDX_CHIP_STAT, 8'h02);
    $display("test enable done");
    msig(3'h6, 1'b1);
    msig(3'h6, 1'b0);
    pulse_fifo(5'h00, 1'b0);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(IDX_CHIP_STAT, 8'h02);
    rd(IDX_MISC_STAT, 8'h00);
    rd(IDX_OVERVIEW, 8'h00);
    msig(3'h6, 1'b1);
    msig(3'h6, 1'b0);
    rd(IDX_CHIP_STAT, 8'h02);
    pulse_fifo(5'h00, 1'b0);
    rd(IDX_BLK0, 8'h00);
    rd(IDX_MISC_STAT, 8'h02);
    $display("test second reset done");
    rd(8'h20, 8'h00, 1'b1);
    wr(IDX_CHIP_STAT, 8'hff, 1'b1);
    wr(IDX_BLK7, 8'hff, 1'b1);
    rd(IDX_CHIP_STAT, 8'h02);
    $display("test refused done");
    report_and_stop();
  end
endmodule
`default_nettype wire
